// File: shcp_pkg.sv
`default_nettype none
package shcp_pkg;
	localparam int NCH      = 4;
	localparam int EDGE_MIN = 8;
	localparam int EDGE_RST = 16;
	localparam int GCI_FS   = 2;

	// ----------------------------------------
	// opcodes (bit 0 set = read of the pair)
	// ----------------------------------------
	localparam logic [7:0] OP_DEACT   = 8'h00;
	localparam logic [7:0] OP_SRST    = 8'h02;
	localparam logic [7:0] OP_HRST    = 8'h04;
	localparam logic [7:0] OP_NOP     = 8'h06;
	localparam logic [7:0] OP_ACT     = 8'h0e;
	localparam logic [7:0] OP_TTS     = 8'h40;
	localparam logic [7:0] OP_RTS     = 8'h42;
	localparam logic [7:0] OP_CSLOT   = 8'h44;
	localparam logic [7:0] OP_CFG     = 8'h46;
	localparam logic [7:0] OP_ENMODE  = 8'h4a;
	localparam logic [7:0] OP_RTD     = 8'h4d;
	localparam logic [7:0] OP_RTD_CLR = 8'h4f;
	localparam logic [7:0] OP_LIO     = 8'h52;
	localparam logic [7:0] OP_MASK    = 8'h6c;
	localparam logic [7:0] OP_REV     = 8'h73;
	localparam logic [7:0] OP_TRANSMIT_SAMPLE_READBACK    = 8'hcd;

	// ----------------------------------------
	// reset values and field positions
	// ----------------------------------------
	localparam logic [31:0] TS_RST     = 32'h03020100;
	localparam logic [7:0]  CSLOT_RST  = 8'h00;
	localparam logic [7:0]  CFG_RST    = 8'h00;
	localparam logic [7:0]  ENMODE_RST = 8'h00;
	localparam logic [7:0]  MASK_RST   = 8'h00;
	localparam logic [7:0]  LIO_RST    = 8'h00;
	localparam int          EC_LSB     = 0;

	typedef enum logic [1:0] {
		SHCP_S_CMD = 2'b00,
		SHCP_S_WR  = 2'b01,
		SHCP_S_RD  = 2'b10
	} shcp_seq_t;

	typedef enum logic [1:0] {
		SHCP_K_NONE = 2'b00,
		SHCP_K_WR   = 2'b01,
		SHCP_K_RD   = 2'b10
	} shcp_kind_t;
endpackage
`default_nettype wire

// File: shcp_link_if.sv
`default_nettype none
interface shcp_link_if;
	logic       cs_n;
	logic       host_shift_clock;
	logic       serial_data_line;
	logic       fs;
	logic       tx_en;
	logic [7:0] tx_byte;
	logic       byte_vld;
	logic [7:0] byte_data;
	logic       overlong;
	logic       gci_req;
	logic       sdo;
	logic       sdo_oe;
	modport framer (input cs_n, host_shift_clock, serial_data_line, fs, tx_en, tx_byte,
		output byte_vld, byte_data, overlong, gci_req, sdo, sdo_oe);
	modport seq (output cs_n, host_shift_clock, serial_data_line, fs, tx_en, tx_byte,
		input byte_vld, byte_data, overlong, gci_req, sdo, sdo_oe);
endinterface
`default_nettype wire

// File: shcp_sync.sv
`default_nettype none
module shcp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s2;
		logic [W-1:0] s1;
	} shcp_sync_t;

	shcp_sync_t q, n;

	always_comb
	begin
		n.s1 = d_i;
		n.s2 = q.s1;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			q <= '0;
		else
			q <= n;
	end

	assign q_o = q.s2;
endmodule
`default_nettype wire

// File: shcp_framer.sv
`default_nettype none
module shcp_framer
	import shcp_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	shcp_link_if.framer lk
);
	typedef struct packed {
		logic [4:0] cnt;
		logic       tog;
		logic [1:0] fs_cnt;
		logic       cs_p;
		logic       host_shift_clock_p;
		logic       fs_p;
		logic [7:0] shift;
		logic [7:0] tx_sh;
		logic       sdo;
		logic       oe;
		logic       vld;
		logic [7:0] data;
		logic       ovl;
		logic       gci;
	} shcp_frm_t;

	shcp_frm_t q, n;
	logic cs_fall, cs_rise, rise, fall, fs_rise;

	assign cs_fall = q.cs_p & ~lk.cs_n;
	assign cs_rise = ~q.cs_p & lk.cs_n;
	assign rise    = lk.host_shift_clock & ~q.host_shift_clock_p;
	assign fall    = ~lk.host_shift_clock & q.host_shift_clock_p;
	assign fs_rise = lk.fs & ~q.fs_p;

	always_comb
	begin
		n = q;
		n.vld = 1'b0;
		n.ovl = 1'b0;
		n.gci = 1'b0;
		n.cs_p = lk.cs_n;
		n.host_shift_clock_p = lk.host_shift_clock;
		n.fs_p = lk.fs;
		if (cs_fall)
		begin
			n.cnt = 5'h00;
			n.tog = 1'b0;
			n.fs_cnt = 2'h0;
			n.tx_sh = lk.tx_byte;
			n.sdo = lk.tx_byte[7];
			n.oe = lk.tx_en;
		end
		else if (!lk.cs_n)
		begin
			if (rise)
			begin
				n.shift = {q.shift[6:0], lk.serial_data_line};
				if (q.cnt != 5'(EDGE_RST))
					n.cnt = q.cnt + 5'h01;
				if (q.cnt == 5'(EDGE_RST - 1))
					n.ovl = 1'b1;
			end
			if (lk.host_shift_clock != q.host_shift_clock_p)
				n.tog = 1'b1;
			if (fall && q.oe && q.cnt != 5'h00)
			begin
				n.tx_sh = {q.tx_sh[6:0], 1'b0};
				n.sdo = q.tx_sh[6];
			end
			// a toggling clock in the same cycle still counts as activity
			if (fs_rise && !q.tog && lk.host_shift_clock == q.host_shift_clock_p && q.fs_cnt != 2'(GCI_FS))
			begin
				n.fs_cnt = q.fs_cnt + 2'h1;
				if (q.fs_cnt == 2'(GCI_FS - 1))
					n.gci = 1'b1;
			end
		end
		if (cs_rise)
		begin
			n.oe = 1'b0;
			n.data = q.shift;
			n.vld = q.cnt >= 5'(EDGE_MIN) && q.cnt < 5'(EDGE_RST);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			q <= '{cs_p: 1'b1, default: '0};
		else
			q <= n;
	end

	assign lk.byte_vld  = q.vld;
	assign lk.byte_data = q.data;
	assign lk.overlong  = q.ovl;
	assign lk.gci_req   = q.gci;
	assign lk.sdo       = q.sdo;
	assign lk.sdo_oe    = q.oe;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_short_frame;
		@(posedge clk_i) disable iff (rst_i)
		(cs_rise && q.cnt < 5'(EDGE_MIN)) |=> !q.vld;
	endproperty
	a_short_frame: assert property (p_short_frame) else $error("short frame accepted");

	property p_last_eight;
		@(posedge clk_i) disable iff (rst_i)
		(cs_rise && q.cnt >= 5'(EDGE_MIN) && q.cnt < 5'(EDGE_RST))
			|=> (q.vld && q.data == $past(q.shift));
	endproperty
	a_last_eight: assert property (p_last_eight) else $error("byte not taken");

	property p_early_bit;
		@(posedge clk_i) disable iff (rst_i)
		(cs_fall && lk.tx_en) |=> (q.oe && q.sdo == $past(lk.tx_byte[7]));
	endproperty
	a_early_bit: assert property (p_early_bit) else $error("msb not driven");

	property p_idle_clock;
		@(posedge clk_i) disable iff (rst_i)
		(lk.cs_n && q.cs_p) |=> ($stable(q.cnt) && $stable(q.shift) && !q.vld);
	endproperty
	a_idle_clock: assert property (p_idle_clock) else $error("state moved while deselected");

	c_overlong: cover property (@(posedge clk_i) disable iff (rst_i) q.ovl);
	c_gci: cover property (@(posedge clk_i) disable iff (rst_i) q.gci);
endmodule
`default_nettype wire

// File: shcp_port.sv
`default_nettype none
module shcp_port
	import shcp_pkg::*;
#(
	parameter logic [7:0] REVISION   = 8'h01, // arbitrary value
	parameter logic [3:0] COEF_BYTES = 4'h1
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            cs_n_i,
	input  wire logic            host_shift_clock_i,
	input  wire logic            serial_data_line_i,
	output var  logic            serial_data_line_o,
	output var  logic            serial_data_line_oe_o,
	input  wire logic            frame_sync_pulse_i,
	input  wire logic [7:0]      realtime_line_state_i,
	input  wire logic [NCH*8-1:0] line_interface_in_i,
	input  wire logic [NCH*8-1:0] tx_sample_i,
	input  wire logic [7:0]      ext_rd_data_i,
	output var  logic [NCH*8-1:0] tx_slot_o,
	output var  logic [NCH*8-1:0] rx_slot_o,
	output var  logic [NCH*8-1:0] clock_slot_o,
	output var  logic [NCH*8-1:0] line_interface_out_o,
	output var  logic [7:0]      config_o,
	output var  logic [NCH-1:0]  channel_select_bits_o,
	output var  logic [7:0]      op_mode_o,
	output var  logic [7:0]      line_state_irq_mask_o,
	output var  logic [NCH-1:0]  chan_active_o,
	output var  logic            gci_mode_o,
	output var  logic            irq_o,
	output var  logic            hw_reset_o,
	output var  logic            soft_reset_o,
	output var  logic            ext_wr_o,
	output var  logic            ext_rd_o,
	output var  logic [7:0]      ext_op_o,
	output var  logic [7:0]      ext_data_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		shcp_seq_t           st;
		logic [7:0]          op;
		logic [3:0]          rem;
		logic [7:0]          tx;
		logic [NCH-1:0][7:0] tts;
		logic [NCH-1:0][7:0] rts;
		logic [NCH-1:0][7:0] cslot;
		logic [NCH-1:0][7:0] lio;
		logic [7:0]          cfg;
		logic [7:0]          enmode;
		logic [7:0]          mask;
		logic [7:0]          ls_prev;
		logic [NCH-1:0]      act;
		logic                gci;
		logic                irq;
		logic                hrst;
		logic                srst;
		logic                ewr;
		logic                erd;
		logic [7:0]          edata;
	} shcp_core_t;

	function automatic shcp_core_t core_reset();
		shcp_core_t c;
		c = '0;
		c.st = SHCP_S_CMD;
		c.tts = TS_RST;
		c.rts = TS_RST;
		c.cslot = {NCH{CSLOT_RST}};
		c.lio = {NCH{LIO_RST}};
		c.cfg = CFG_RST;
		c.enmode = ENMODE_RST;
		c.mask = MASK_RST;
		return c;
	endfunction

	localparam shcp_core_t CORE_RST = core_reset();

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [1:0] first_ch(input logic [NCH-1:0] en);
		first_ch = 2'h0;
		for (int i = NCH - 1; i >= 0; i--)
			if (en[i])
				first_ch = 2'(i);
	endfunction

	function automatic shcp_kind_t op_kind(input logic [7:0] b);
		case ({b[7:1], 1'b0})
			OP_TTS, OP_RTS, OP_CSLOT, OP_CFG, OP_ENMODE, OP_LIO, OP_MASK,
			8'h50, 8'h54, 8'h60, 8'h70, 8'h80, 8'h82, 8'h84, 8'h86, 8'h88,
			8'h8a, 8'h96, 8'h98, 8'h9a, 8'hc8, 8'he8:
				op_kind = b[0] ? SHCP_K_RD : SHCP_K_WR;
			default:
				op_kind = (b == OP_RTD || b == OP_RTD_CLR || b == OP_REV || b == OP_TRANSMIT_SAMPLE_READBACK)
					? SHCP_K_RD : SHCP_K_NONE;
		endcase
	endfunction

	function automatic logic is_local(input logic [7:0] b);
		case ({b[7:1], 1'b0})
			OP_TTS, OP_RTS, OP_CSLOT, OP_CFG, OP_ENMODE, OP_LIO, OP_MASK:
				is_local = 1'b1;
			default:
				is_local = b == OP_RTD || b == OP_RTD_CLR || b == OP_REV || b == OP_TRANSMIT_SAMPLE_READBACK;
		endcase
	endfunction

	// coefficient blocks are handed to the datapath byte by byte
	function automatic logic [3:0] data_len(input logic [7:0] b);
		data_len = (b[7] && b[7:4] != 4'hc && b[7:4] != 4'he) ? COEF_BYTES : 4'h1;
	endfunction

	// ----------------------------------------
	// pin synchronisers and framer
	// ----------------------------------------
	shcp_link_if lk ();
	logic [4+8+NCH*8-1:0] sy;
	logic [7:0]           ls;
	logic [NCH*8-1:0]     li;

	shcp_sync #(.W(4 + 8 + NCH * 8)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({~cs_n_i, host_shift_clock_i, serial_data_line_i, frame_sync_pulse_i,
			realtime_line_state_i, line_interface_in_i}),
		.q_o   (sy)
	);

	assign lk.cs_n = ~sy[4+8+NCH*8-1]; // inverted: cleared flops read as deselected
	assign lk.host_shift_clock = sy[4+8+NCH*8-2];
	assign lk.serial_data_line  = sy[4+8+NCH*8-3];
	assign lk.fs   = sy[4+8+NCH*8-4];
	assign ls      = sy[8+NCH*8-1 -: 8];
	assign li      = sy[NCH*8-1:0];

	shcp_framer u_framer (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.lk    (lk)
	);

	shcp_core_t q, n;
	logic [NCH-1:0] en;
	logic [1:0]     ch;
	logic [7:0]     b;
	logic           take;
	logic           irq_set;
	logic           irq_clr;
	logic           hw;

	assign en = q.enmode[EC_LSB +: NCH];
	assign ch = first_ch(en);
	assign b = lk.byte_data;
	// the host port takes no more bytes once gci mode is taken; an overlong frame still resets
	assign take = lk.byte_vld && !q.gci;
	assign lk.tx_en = q.st == SHCP_S_RD;
	assign lk.tx_byte = q.tx;

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_comb
	begin
		n = q;
		n.hrst = 1'b0;
		n.srst = 1'b0;
		n.ewr = 1'b0;
		n.erd = 1'b0;
		irq_clr = 1'b0;
		hw = lk.overlong;
		case (q.op)
			OP_TTS | 8'h01:    n.tx = q.tts[ch];
			OP_RTS | 8'h01:    n.tx = q.rts[ch];
			OP_CSLOT | 8'h01:  n.tx = q.cslot[ch];
			OP_CFG | 8'h01:    n.tx = q.cfg;
			OP_ENMODE | 8'h01: n.tx = q.enmode;
			OP_LIO | 8'h01:    n.tx = li[{ch, 3'h0} +: 8];
			OP_MASK | 8'h01:   n.tx = q.mask;
			OP_RTD, OP_RTD_CLR: n.tx = ls;
			OP_REV:            n.tx = REVISION;
			OP_TRANSMIT_SAMPLE_READBACK:           n.tx = tx_sample_i[{ch, 3'h0} +: 8];
			default:           n.tx = ext_rd_data_i;
		endcase
		if (take)
		begin
			case (q.st)
				SHCP_S_CMD:
				begin
					n.op = b;
					n.rem = data_len(b);
					case (op_kind(b))
						SHCP_K_RD:
						begin
							n.st = SHCP_S_RD;
							irq_clr = b == OP_RTD_CLR;
						end
						SHCP_K_WR: n.st = SHCP_S_WR;
						default:
						begin
							case (b)
								OP_DEACT: n.act = q.act & ~en;
								OP_ACT:   n.act = q.act | en;
								OP_SRST:
								begin
									n.srst = 1'b1;
									n.act = q.act & ~en;
									for (int i = 0; i < NCH; i++)
										if (en[i])
											n.lio[i] = LIO_RST;
								end
								OP_HRST: hw = 1'b1;
								default: ;
							endcase
						end
					endcase
				end
				SHCP_S_WR:
				begin
					n.rem = q.rem - 4'h1;
					if (q.rem == 4'h1)
						n.st = SHCP_S_CMD;
					// full bytes stored; unused bits are the host's care
					case (q.op)
						OP_CFG:    n.cfg = b;
						OP_ENMODE: n.enmode = b;
						OP_MASK:   n.mask = b;
						OP_TTS, OP_RTS, OP_CSLOT, OP_LIO:
						begin
							for (int i = 0; i < NCH; i++)
								if (en[i])
								begin
									if (q.op == OP_TTS)
										n.tts[i] = b;
									if (q.op == OP_RTS)
										n.rts[i] = b;
									if (q.op == OP_CSLOT)
										n.cslot[i] = b;
									if (q.op == OP_LIO)
										n.lio[i] = b;
								end
						end
						default:
						begin
							n.ewr = 1'b1;
							n.edata = b;
						end
					endcase
				end
				SHCP_S_RD:
				begin
					n.rem = q.rem - 4'h1;
					n.erd = !is_local(q.op);
					if (q.rem == 4'h1)
						n.st = SHCP_S_CMD;
				end
				default: n.st = SHCP_S_CMD;
			endcase
		end
		// a change landing with the clear keeps the interrupt pending
		irq_set = |((ls ^ q.ls_prev) & ~q.mask);
		n.irq = irq_set | (q.irq & ~irq_clr);
		n.ls_prev = ls;
		if (lk.gci_req)
			n.gci = 1'b1;
		if (hw)
		begin
			n = CORE_RST;
			n.hrst = 1'b1;
			n.ls_prev = ls;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			q <= CORE_RST;
		else
			q <= n;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign serial_data_line_o    = lk.sdo;
	assign serial_data_line_oe_o = lk.sdo_oe;
	assign tx_slot_o             = q.tts;
	assign rx_slot_o             = q.rts;
	assign clock_slot_o          = q.cslot;
	assign line_interface_out_o  = q.lio;
	assign config_o              = q.cfg;
	assign channel_select_bits_o = en;
	assign op_mode_o             = q.enmode;
	assign line_state_irq_mask_o = q.mask;
	assign chan_active_o         = q.act;
	assign gci_mode_o            = q.gci;
	assign irq_o                 = q.irq;
	assign hw_reset_o            = q.hrst;
	assign soft_reset_o          = q.srst;
	assign ext_wr_o              = q.ewr;
	assign ext_rd_o              = q.erd;
	assign ext_op_o              = q.op;
	assign ext_data_o            = q.edata;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_ovl_reset;
		@(posedge clk_i) disable iff (rst_i)
		lk.overlong |=> (hw_reset_o && q.st == SHCP_S_CMD && q.tts == TS_RST);
	endproperty
	a_ovl_reset: assert property (p_ovl_reset) else $error("overlong frame kept state");

	property p_read_hold;
		@(posedge clk_i) disable iff (rst_i)
		(q.st == SHCP_S_RD && take && q.rem > 4'h1) |=> (q.st == SHCP_S_RD);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read cut short");

	property p_write_end;
		@(posedge clk_i) disable iff (rst_i)
		(q.st == SHCP_S_WR && take && q.rem == 4'h1 && !lk.overlong) |=> (q.st == SHCP_S_CMD);
	endproperty
	a_write_end: assert property (p_write_end) else $error("write not closed");

	property p_broadcast;
		@(posedge clk_i) disable iff (rst_i)
		(q.st == SHCP_S_WR && take && q.op == OP_TTS && !lk.overlong)
			|=> (!$past(en[3]) || q.tts[3] == $past(b)) && (!$past(en[0]) || q.tts[0] == $past(b));
	endproperty
	a_broadcast: assert property (p_broadcast) else $error("enabled channel missed");

	property p_rtd_clear;
		@(posedge clk_i) disable iff (rst_i)
		(q.st == SHCP_S_CMD && take && b == OP_RTD_CLR && !lk.overlong)
			|=> (q.st == SHCP_S_RD && q.rem == 4'h1) ##1 (q.tx == $past(ls));
	endproperty
	a_rtd_clear: assert property (p_rtd_clear) else $error("realtime read wrong");

	property p_gci;
		@(posedge clk_i) disable iff (rst_i)
		(lk.gci_req && !lk.overlong) |=> gci_mode_o ##1 gci_mode_o;
	endproperty
	a_gci: assert property (p_gci) else $error("gci not taken");

	property p_reserved;
		@(posedge clk_i) disable iff (rst_i)
		(q.st == SHCP_S_CMD && take && op_kind(b) == SHCP_K_NONE && b[7:4] != 4'h0 && !lk.overlong)
			|=> (q.st == SHCP_S_CMD && $stable(q.enmode) && $stable(q.act));
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved opcode acted");

	property p_soft_reset;
		@(posedge clk_i) disable iff (rst_i)
		(q.st == SHCP_S_CMD && take && b == OP_SRST && !lk.overlong)
			|=> (soft_reset_o && (q.act & $past(en)) == '0 && $stable(q.tts));
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

	c_read_done: cover property (@(posedge clk_i) disable iff (rst_i)
		q.st == SHCP_S_RD && take && q.rem == 4'h1);
	c_write_done: cover property (@(posedge clk_i) disable iff (rst_i)
		q.st == SHCP_S_WR && take);
	c_irq: cover property (@(posedge clk_i) disable iff (rst_i) irq_set);
endmodule
`default_nettype wire

// File: shcp_host_model.sv
`default_nettype none
// ----------------------------------------
// host side: one n-bit frame per select period
// ----------------------------------------
module shcp_host_model (
	input  wire logic       clk_i,
	input  wire logic       dev_i,
	input  wire logic       dev_oe_i,
	output var  logic       cs_n_o,
	output var  logic       sclk_o,
	output wire logic       line_o,
	output var  logic [7:0] rd_byte_o,
	output var  logic       rd_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drv_q;
	logic drv_en_q;
	// pull-up: a released line reads high
	assign line_o = dev_oe_i ? dev_i : (drv_en_q ? drv_q : 1'b1);
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		drv_q = 1'b1;
		drv_en_q = 1'b0;
		rd_byte_o = 8'h00;
		rd_done_o = 1'b0;
	end
	task automatic frame(input logic [15:0] bits, input int n, input bit rd);
		@(negedge clk_i);
		cs_n_o = 1'b0;
		drv_en_q = !rd;
		for (int i = n - 1; i >= 0; i--)
		begin
			drv_q = bits[i]; // msb first
			repeat (8) @(negedge clk_i);
			sclk_o = 1'b1;
			rd_byte_o = {rd_byte_o[6:0], line_o};
			repeat (8) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		repeat (8) @(negedge clk_i);
		cs_n_o = 1'b1; // one n-bit frame per select period
		drv_en_q = 1'b0;
		repeat (8) @(negedge clk_i); // off time, also lets a read byte load
		rd_done_o = rd;
		@(negedge clk_i);
		rd_done_o = 1'b0;
	endtask
	task automatic hold(input logic v);
		@(negedge clk_i);
		cs_n_o = v;
	endtask
	task automatic idle_clk(input int k);
		repeat (k)
		begin
			repeat (8) @(negedge clk_i);
			sclk_o = ~sclk_o;
		end
	endtask
endmodule
`default_nettype wire

// File: test_serial_host_command_port.sv
`default_nettype none
module test_serial_host_command_port;
	timeunit 1ns;
	timeprecision 1ps;
	import shcp_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic fs = 1'b0;
	logic [7:0] rt;
	logic [31:0] lin, txs, tx_exp;
	logic [7:0] ext_rd, r, m, v;
	wire logic cs_n, sclk, line, sdo, oe, rd_done;
	logic [7:0] rd_byte;
	logic [31:0] tx_slot, rx_slot, cslot, lio_out;
	logic [7:0] cfg, mask;
	logic gci, irq, hrst, srst, ewr, erd;
	logic [7:0] opm, eop, edat;
	logic [3:0] ens, act;
	logic [7:0] exp_q[$];
	int n_errors = 0;
	int cmp_count = 0;
	int n_hrst = 0;
	int n_srst = 0;
	int n_ewr = 0;
	int n_erd = 0;
	always #2.5 clk_i = ~clk_i;
	shcp_host_model host (.clk_i(clk_i), .dev_i(sdo), .dev_oe_i(oe), .cs_n_o(cs_n),
		.sclk_o(sclk), .line_o(line), .rd_byte_o(rd_byte), .rd_done_o(rd_done));
	shcp_port #(.REVISION(8'h5a), .COEF_BYTES(4'h2)) dut ( // revision arbitrary
		.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .host_shift_clock_i(sclk),
		.serial_data_line_i(line), .serial_data_line_o(sdo), .serial_data_line_oe_o(oe),
		.frame_sync_pulse_i(fs), .realtime_line_state_i(rt), .line_interface_in_i(lin),
		.tx_sample_i(txs), .ext_rd_data_i(ext_rd), .tx_slot_o(tx_slot), .rx_slot_o(rx_slot),
		.clock_slot_o(cslot), .line_interface_out_o(lio_out), .config_o(cfg),
		.channel_select_bits_o(ens), .op_mode_o(opm), .line_state_irq_mask_o(mask),
		.chan_active_o(act), .gci_mode_o(gci), .irq_o(irq), .hw_reset_o(hrst),
		.soft_reset_o(srst), .ext_wr_o(ewr), .ext_rd_o(erd), .ext_op_o(eop),
		.ext_data_o(edat));
	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// watcher: each finished read byte meets the oldest note
	always @(posedge rd_done)
		check("read byte", rd_byte, exp_q.pop_front());
	// one-cycle pulses, counted mid-cycle where they stand
	always @(negedge clk_i)
	begin
		n_hrst += int'(hrst);
		n_srst += int'(srst);
		n_ewr += int'(ewr);
		n_erd += int'(erd);
	end
	task automatic wr(input logic [7:0] op, input logic [7:0] d);
		host.frame({8'h00, op}, 8, 1'b0);
		host.frame({8'h00, d}, 8, 1'b0); // data frame, not a command
	endtask
	task automatic rd(input logic [7:0] op, input logic [7:0] exp);
		host.frame({8'h00, op}, 8, 1'b0);
		exp_q.push_back(exp);
		host.frame(16'h0000, 8, 1'b1); // bit seen before first clock edge
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(94));
		rt = 8'($urandom());
		lin = $urandom();
		txs = $urandom();
		ext_rd = 8'($urandom());
		r = 8'($urandom());
		m = 8'($urandom() & 32'h7f); // bit 7 stays unmasked for the interrupt test
		v = 8'($urandom() | 32'h1);
		repeat (16) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		check("reset", {tx_slot, rx_slot, cslot, cfg, mask, gci},
			{TS_RST, TS_RST, 32'h0, CFG_RST, MASK_RST, 1'b0});
		wr(OP_ENMODE, 8'h05); // channels 0 and 2
		check("enable", {opm, ens}, {8'h05, 4'h5});
		wr(OP_TTS, r);
		tx_exp = {TS_RST[31:24], r, TS_RST[15:8], r};
		check("broadcast", tx_slot, tx_exp);
		wr(OP_RTS, v);
		check("rx slot", rx_slot, {TS_RST[31:24], v, TS_RST[15:8], v});
		rd(OP_TTS | 8'h01, r); // lowest enabled channel
		rd(OP_RTS | 8'h01, v);
		rd(OP_ENMODE | 8'h01, 8'h05);
		host.frame({8'h00, OP_TTS}, 5, 1'b0); // short frame ignored
		host.frame({8'h0f, OP_MASK}, 12, 1'b0); // last 8 edges count
		host.frame({8'h00, m}, 8, 1'b0);
		check("mask", mask, m);
		host.frame({8'h00, 8'h3c}, 8, 1'b0); // reserved, no data
		rd(OP_MASK | 8'h01, m);
		rd(OP_REV, 8'h5a);
		rd(OP_TRANSMIT_SAMPLE_READBACK, txs[7:0]);
		rd(OP_LIO | 8'h01, lin[7:0]);
		rt = rt ^ ~m; // an unmasked line change raises the interrupt
		rd(OP_RTD, rt);
		check("irq kept", irq, 1'b1);
		rd(OP_RTD_CLR, rt);
		check("irq cleared", irq, 1'b0);
		wr(OP_LIO, v);
		check("line out", lio_out, {8'h00, v, 8'h00, v});
		wr(OP_CSLOT, v); // per-channel clock slot to the enabled channels, then the global config
		wr(OP_CFG, v);
		check("globals", {cslot, cfg}, {8'h00, v, 8'h00, v, v});
		rd(OP_CSLOT | 8'h01, v);
		rd(OP_CFG | 8'h01, v);
		host.frame({8'h00, OP_ACT}, 8, 1'b0);
		check("activate", act, 4'h5);
		host.frame({8'h00, OP_DEACT}, 8, 1'b0);
		check("deactivate", act, 4'h0);
		host.frame({8'h00, OP_ACT}, 8, 1'b0);
		host.frame({8'h00, OP_SRST}, 8, 1'b0);
		check("soft reset", {lio_out, tx_slot, cslot, act},
			{32'h0, tx_exp, 8'h00, v, 8'h00, v, 4'h0});
		check("soft pulse", n_srst, 1);
		host.frame({8'h00, 8'h80}, 8, 1'b0); // two-byte coefficient write
		host.frame({8'h00, r}, 8, 1'b0);
		host.frame({8'h00, v}, 8, 1'b0);
		check("ext write", {n_ewr, eop, edat}, {32'd2, 8'h80, v});
		host.frame({8'h00, 8'h81}, 8, 1'b0);
		repeat (2)
		begin
			exp_q.push_back(ext_rd);
			host.frame(16'h0000, 8, 1'b1);
		end
		check("ext read", n_erd, 2);
		host.idle_clk(20); // deselected clock activity
		check("idle clock", {tx_slot, mask}, {tx_exp, m});
		host.frame(16'h4a4a, 16, 1'b0); // overlong frame resets all
		check("overlong", {tx_slot, mask, cslot}, {TS_RST, MASK_RST, 32'h0});
		wr(OP_MASK, m);
		host.frame({8'h00, OP_HRST}, 8, 1'b0);
		check("reset pulses", {mask, n_hrst}, {MASK_RST, 32'd2});
		host.hold(1'b0);
		repeat (2)
		begin
			repeat (10) @(negedge clk_i);
			fs = 1'b1;
			repeat (10) @(negedge clk_i);
			fs = 1'b0;
		end
		for (int i = 0; i < 20 && gci !== 1'b1; i++)
			@(negedge clk_i);
		check("gci switch", gci, 1'b1);
		host.hold(1'b1);
		repeat (20) @(negedge clk_i);
		check("notes left", exp_q.size(), 0);
		test_done();
	end
endmodule
`default_nettype wire
